// >>> bcp_pkg.sv
package bcp_pkg;
  // ----------------------------------------------------------------
  // boot partition address ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] BOOT_LO_START = 16'h0000;
  localparam logic [15:0] BOOT_LO_END = 16'h01ff;
  localparam logic [15:0] BOOT_HI_START = 16'h8000;
  localparam logic [15:0] BOOT_HI_END = 16'h800f;
  // ----------------------------------------------------------------
  // command codes written into the boot partition
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_LOAD_1 = 16'h00e0;
  localparam logic [15:0] CMD_LOAD_2 = 16'h0000;
  localparam logic [15:0] CMD_READ_ID = 16'h0090;
  // ----------------------------------------------------------------
  // identification offsets inside the boot partition
  // ----------------------------------------------------------------
  localparam logic [15:0] ID_OFS_MAKER = 16'h0000;
  localparam logic [15:0] ID_OFS_DEVICE = 16'h0001;
  localparam logic [15:0] ID_OFS_PROTECT = 16'h0002;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_BLOCK_SEL = 16'hf100;
  localparam logic [15:0] OFS_PAGE_SEL = 16'hf107;
  localparam logic [15:0] OFS_ECC2_MAIN = 16'hff05;
  localparam logic [15:0] OFS_ECC2_SPARE = 16'hff06;
  localparam logic [15:0] OFS_ECC3_MAIN = 16'hff07;
  localparam logic [15:0] OFS_ECC3_SPARE = 16'hff08;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int WORD_POS_LSB = 4;   // err_word_position at [11:4]
  localparam int LANE_LSB = 0;       // err_bit_lane at [3:0]
  localparam int SPARE_SEL_LSB = 4;  // spare_err_word_select at [5:4]
  localparam int PAGE_SEL_LSB = 2;   // flash_page_select at [7:2] of page register
  localparam logic [15:0] ECC_RESET = 16'h0000;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [1:0] SPARE_WORD2 = 2'h0;
  localparam logic [1:0] SPARE_WORD3 = 2'h1;
  // ----------------------------------------------------------------
  // pin synchroniser depth and command states
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {ST_READY, ST_LOAD_ARMED, ST_ID_MODE, ST_LOAD_BUSY} bcp_state_t;
endpackage

// >>> bcp_boot_cmd_port.sv
`timescale 1ns/1ps
// Contract
// - main result reports error word among 256
// - result carries which of 16 lanes
// - results update during boot load too
// - spare select bits 5:4, 00/01 words
// - commands accepted only at boot addresses
// - boot area 0000-01ff and 8000-800f
// - boot data read only before any command
// - other writes go to buffers/registers
// - execute only after all cycles received
// - bad boot write returns to ready; while a load is busy only f0 does, other boot writes are ignored
// - commands only from asynchronous cycles
// - f0 write resets all registers; selects kept if it is the second load cycle, results kept while busy
// - e0 then 0000 loads one page
// - page increments, wraps inside block
// - 90 then read maker, device, protection
// - write strobe toggle ends identification
// - burst read start, data while oe low
// - burst write start, data while oe high
// - any command clears result registers; not while a load is busy, and a same-cycle update wins
module bcp_boot_cmd_port
  import bcp_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h0a5a,  // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0c3c, // arbitrary value
  parameter int PAGE_BITS = 6                    // 64 pages of 2KB per 128KB block
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic warm_reset_n,
  input wire logic address_valid_n,
  input wire logic burst_clk,
  input wire logic [15:0] addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] boot_rd_data,
  input wire logic [15:0] buf_rd_data,
  input wire logic [15:0] protect_status,
  output logic buf_wr,
  output logic [15:0] buf_addr,
  output logic [15:0] buf_wdata,
  output logic load_req,
  output logic [15:0] load_block,
  output logic [PAGE_BITS-1:0] load_page,
  input wire logic load_done,
  output logic core_reset,
  input wire logic ecc_upd,
  input wire logic ecc_upd_sector,
  input wire logic [7:0] ecc_upd_word,
  input wire logic [3:0] ecc_upd_main_lane,
  input wire logic [1:0] ecc_upd_spare_sel,
  input wire logic [3:0] ecc_upd_spare_lane
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 38;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  assign pin_raw = {chip_sel_n, out_en_n, write_n, warm_reset_n, address_valid_n, burst_clk, addr, dq_i};

  // each bit takes a new value only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          pin_s1_q[gi] <= 1'b1;
          pin_s2_q[gi] <= 1'b1;
          pin_s3_q[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // filtered pin levels
  logic ce_n_f, oe_n_f, we_n_f, rp_n_f, avd_n_f, bclk_f;
  logic [15:0] addr_f, data_f;
  assign {ce_n_f, oe_n_f, we_n_f, rp_n_f, avd_n_f, bclk_f, addr_f, data_f} = pin_q;

  // ----------------------------------------------------------------
  // strobe edges and decode
  // ----------------------------------------------------------------
  logic we_n_prev_q, bclk_prev_q;
  logic we_rise, bclk_rise;
  assign we_rise = we_n_f & ~we_n_prev_q;
  assign bclk_rise = bclk_f & ~bclk_prev_q;

  // boot partition test, shared by write and read paths
  function automatic logic in_boot(input logic [15:0] a);
    in_boot = (a <= BOOT_LO_END) || (a >= BOOT_HI_START && a <= BOOT_HI_END);
  endfunction

  logic burst_q, burst_rd_q;
  logic [15:0] burst_addr_q;
  logic async_wr, cmd_wr, plain_wr, burst_wr, addr_boot;
  logic soft_rst, any_rst;
  assign addr_boot = in_boot(addr_f);
  // asynchronous write: ce low, clock held low, not inside a burst
  assign async_wr = we_rise & ~ce_n_f & oe_n_f & ~bclk_f & ~burst_q;
  assign cmd_wr = async_wr & addr_boot;
  assign plain_wr = async_wr & ~addr_boot;
  assign burst_wr = burst_q & ~burst_rd_q & bclk_rise & oe_n_f & ~ce_n_f;

  // ----------------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------------
  bcp_state_t state_q, state_d;
  logic cmd_seen_q;
  logic start_load, cmd_accept;
  assign soft_rst = cmd_wr && state_q != ST_LOAD_ARMED && data_f == CMD_RESET;
  assign any_rst = sys_rst | ~rp_n_f | soft_rst;
  assign start_load = cmd_wr && state_q == ST_LOAD_ARMED && data_f == CMD_LOAD_2;

  // next-state decode; outside a busy load, any unexpected boot write falls back to ready
  always_comb begin
    state_d = state_q;
    cmd_accept = 1'b0;
    unique case (state_q)
      ST_READY, ST_ID_MODE: begin
        if (we_rise && state_q == ST_ID_MODE) begin
          state_d = ST_READY;
        end
        if (cmd_wr) begin
          cmd_accept = 1'b1;
          if (data_f == CMD_LOAD_1) begin
            state_d = ST_LOAD_ARMED;
          end else if (data_f == CMD_READ_ID) begin
            state_d = ST_ID_MODE;
          end else begin
            state_d = ST_READY;
          end
        end
      end
      ST_LOAD_ARMED: begin
        if (cmd_wr) begin
          cmd_accept = 1'b1;
          state_d = start_load ? ST_LOAD_BUSY : ST_READY;
        end
      end
      ST_LOAD_BUSY: begin
        if (load_done) begin
          state_d = ST_READY;
        end
      end
    endcase
  end

  // state register; a reset command drops straight back to ready
  always_ff @(posedge clock) begin
    if (any_rst) begin
      state_q <= ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // remembers that a command was written since reset
  always_ff @(posedge clock) begin
    if (sys_rst || ~rp_n_f) begin
      cmd_seen_q <= 1'b0;
    end else if (cmd_accept) begin
      cmd_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // block and page selection registers
  // ----------------------------------------------------------------
  logic [15:0] block_sel_q;
  logic [PAGE_BITS-1:0] page_sel_q;

  // the page increment wraps so repeated loads never leave the block
  always_ff @(posedge clock) begin
    if (any_rst) begin
      block_sel_q <= SEL_RESET;
      page_sel_q <= SEL_RESET[PAGE_BITS-1:0];
    end else begin
      if (plain_wr && addr_f == OFS_BLOCK_SEL) begin
        block_sel_q <= data_f;
      end
      if (state_q == ST_LOAD_BUSY && load_done) begin
        page_sel_q <= page_sel_q + 1'b1;
      end else if (plain_wr && addr_f == OFS_PAGE_SEL) begin
        page_sel_q <= data_f[PAGE_SEL_LSB +: PAGE_BITS];
      end
    end
  end

  // ----------------------------------------------------------------
  // ecc result registers
  // ----------------------------------------------------------------
  logic [7:0] ecc_word_q [2];
  logic [3:0] ecc_mlane_q [2];
  logic [1:0] ecc_ssel_q [2];
  logic [3:0] ecc_slane_q [2];

  // updates are taken at any time, boot load included; an update in the
  // same cycle as a command clear wins so no result is lost
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ecc
      always_ff @(posedge clock) begin
        if (sys_rst || ~rp_n_f) begin
          ecc_word_q[gi] <= ECC_RESET[7:0];
          ecc_mlane_q[gi] <= ECC_RESET[3:0];
          ecc_ssel_q[gi] <= ECC_RESET[1:0];
          ecc_slane_q[gi] <= ECC_RESET[3:0];
        end else if (ecc_upd && ecc_upd_sector == 1'(gi)) begin
          ecc_word_q[gi] <= ecc_upd_word;
          ecc_mlane_q[gi] <= ecc_upd_main_lane;
          ecc_ssel_q[gi] <= ecc_upd_spare_sel;
          ecc_slane_q[gi] <= ecc_upd_spare_lane;
        end else if (cmd_accept) begin
          ecc_word_q[gi] <= ECC_RESET[7:0];
          ecc_mlane_q[gi] <= ECC_RESET[3:0];
          ecc_ssel_q[gi] <= ECC_RESET[1:0];
          ecc_slane_q[gi] <= ECC_RESET[3:0];
        end
      end
    end
  endgenerate

  // register images with reserved bits at zero
  logic [15:0] main_img [2];
  logic [15:0] spare_img [2];
  assign main_img[0] = {4'h0, ecc_word_q[0], ecc_mlane_q[0]};
  assign main_img[1] = {4'h0, ecc_word_q[1], ecc_mlane_q[1]};
  assign spare_img[0] = {10'h000, ecc_ssel_q[0], ecc_slane_q[0]};
  assign spare_img[1] = {10'h000, ecc_ssel_q[1], ecc_slane_q[1]};

  // ----------------------------------------------------------------
  // burst tracking
  // ----------------------------------------------------------------
  logic burst_start;
  assign burst_start = ~ce_n_f & ~avd_n_f & bclk_rise & oe_n_f;

  // a burst ends with chip select high or the warm-reset pin low
  always_ff @(posedge clock) begin
    if (sys_rst || ce_n_f || ~rp_n_f) begin
      burst_q <= 1'b0;
      burst_rd_q <= 1'b0;
      burst_addr_q <= 16'h0000;
    end else if (burst_start) begin
      burst_q <= 1'b1;
      burst_rd_q <= we_n_f;
      burst_addr_q <= addr_f;
    end else if (burst_q && bclk_rise && (burst_rd_q ? ~oe_n_f : oe_n_f)) begin
      burst_addr_q <= burst_addr_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [15:0] rd_addr, id_data, rd_data, reg_data;
  logic rd_active;
  assign rd_addr = burst_q ? burst_addr_q : addr_f;
  assign rd_active = ~ce_n_f & ~oe_n_f & we_n_f & rp_n_f & (burst_q ? burst_rd_q : ~bclk_f);
  assign id_data = (addr_f == ID_OFS_MAKER) ? MAKER_CODE :
                   (addr_f == ID_OFS_DEVICE) ? DEVICE_CODE :
                   (addr_f == ID_OFS_PROTECT) ? protect_status : 16'h0000;
  assign reg_data = (rd_addr == OFS_ECC2_MAIN) ? main_img[0] :
                    (rd_addr == OFS_ECC2_SPARE) ? spare_img[0] :
                    (rd_addr == OFS_ECC3_MAIN) ? main_img[1] :
                    (rd_addr == OFS_ECC3_SPARE) ? spare_img[1] : buf_rd_data;
  // boot reads after a command give command results, not boot data
  assign rd_data = (~burst_q && in_boot(rd_addr)) ?
                   (state_q == ST_ID_MODE ? id_data : (cmd_seen_q ? 16'h0000 : boot_rd_data)) : reg_data;

  // output drive; the bus floats in standby and in warm reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      dq_o <= rd_data;
      dq_oe <= rd_active;
    end
  end

  // ----------------------------------------------------------------
  // buffer writes and load requests
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buf_wr <= 1'b0;
      buf_addr <= 16'h0000;
      buf_wdata <= 16'h0000;
      load_req <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      buf_wr <= plain_wr | burst_wr;
      buf_addr <= burst_wr ? burst_addr_q : addr_f;
      buf_wdata <= data_f;
      load_req <= start_load;
      core_reset <= soft_rst;
    end
  end
  assign load_block = block_sel_q;
  assign load_page = page_sel_q;

  // edge history
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      we_n_prev_q <= 1'b1;
      bclk_prev_q <= 1'b1;
    end else begin
      we_n_prev_q <= we_n_f;
      bclk_prev_q <= bclk_f;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence load_pair_s;
    state_q == ST_LOAD_ARMED && start_load;
  endsequence
  sequence load_issue_s;
    load_req && state_q == ST_LOAD_BUSY;
  endsequence

  load_after_two_a: assert property (@(posedge clock) disable iff (sys_rst)
    load_pair_s |=> load_issue_s) else $error("load not issued after second cycle");
  load_needs_pair_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(load_req) |-> $past(state_q) == ST_LOAD_ARMED) else $error("load without full sequence");
  page_step_a: assert property (@(posedge clock) disable iff (sys_rst || ~rp_n_f)
    (state_q == ST_LOAD_BUSY && load_done && !soft_rst) |=> page_sel_q == $past(page_sel_q) + 1'b1)
    else $error("page not advanced");
  bad_cmd_ready_a: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_wr && state_q == ST_LOAD_ARMED && data_f != CMD_LOAD_2) |=> state_q == ST_READY)
    else $error("bad sequence not abandoned");
  cmd_clears_ecc_a: assert property (@(posedge clock) disable iff (sys_rst)
    (cmd_accept && !ecc_upd) |=> main_img[0] == 16'h0000 && spare_img[1] == 16'h0000)
    else $error("ecc results not cleared");
  ecc_capture_a: assert property (@(posedge clock) disable iff (sys_rst || ~rp_n_f)
    (ecc_upd && ecc_upd_sector) |=> main_img[1][11:4] == $past(ecc_upd_word)) else $error("word not captured");
  spare_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    spare_img[0][15:6] == 10'h000 && main_img[1][15:12] == 4'h0) else $error("reserved bits set");
  reset_cmd_a: assert property (@(posedge clock) disable iff (sys_rst)
    soft_rst |=> core_reset && block_sel_q == SEL_RESET && state_q == ST_READY) else $error("reset command ignored");
  outside_no_cmd_a: assert property (@(posedge clock) disable iff (sys_rst)
    (async_wr && !addr_boot) |=> buf_wr && !load_req && !core_reset) else $error("outside write decoded");
  float_standby_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ce_n_f || ~rp_n_f) |=> !dq_oe && !burst_q) else $error("bus driven in standby");
  id_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_ID_MODE && we_rise && !cmd_wr) |=> state_q == ST_READY) else $error("id mode not left");
endmodule

// >>> bcp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host on the pin bus: plain asynchronous cycles and two-word burst cycles
// ----------------------------------------------------------------
module bcp_host_model (
  input wire logic clock,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_n,
  output logic warm_reset_n,
  output logic address_valid_n,
  output logic burst_clk,
  output logic [15:0] addr,
  output logic [15:0] dq_i,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe
);
  // idle pins; burst clock stays low so no cycle turns into a burst
  initial begin
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    write_n = 1'b1;
    warm_reset_n = 1'b1;
    address_valid_n = 1'b1;
    burst_clk = 1'b0;
    addr = 16'h0000;
    dq_i = 16'h0000;
  end

  // write cycle; each level held well past the pin filter depth
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    addr <= a;
    dq_i <= d;
    repeat (5) @(posedge clock);
    write_n <= 1'b0;
    repeat (6) @(posedge clock);
    write_n <= 1'b1;
    repeat (6) @(posedge clock);
    chip_sel_n <= 1'b1;
    // released bus shows no stale value
    addr <= ~a;
    dq_i <= ~d;
    repeat (6) @(posedge clock);
  endtask

  // read cycle; sampled after the edge so registered data has landed
  task automatic rd(input logic [15:0] a, output logic [16:0] v);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    out_en_n <= 1'b0;
    addr <= a;
    repeat (8) @(posedge clock);
    #1 v = {dq_oe, dq_o};
    @(posedge clock);
    out_en_n <= 1'b1;
    chip_sel_n <= 1'b1;
    addr <= ~a;
    repeat (6) @(posedge clock);
  endtask

  // burst write of two words; address valid drops only for the start edge
  task automatic bwr(input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    write_n <= 1'b0;
    address_valid_n <= 1'b0;
    addr <= a;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b1;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b0;
    address_valid_n <= 1'b1;
    dq_i <= d0;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b1;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b0;
    dq_i <= d1;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b1;
    repeat (5) @(posedge clock);
    // chip select and strobe rise together so no plain write is taken
    chip_sel_n <= 1'b1;
    write_n <= 1'b1;
    burst_clk <= 1'b0;
    addr <= ~a;
    dq_i <= ~d1;
    repeat (6) @(posedge clock);
  endtask

  // burst read of two words: start address, then one advance
  task automatic brd(input logic [15:0] a, output logic [16:0] v0, output logic [16:0] v1);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    address_valid_n <= 1'b0;
    addr <= a;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b1;
    repeat (5) @(posedge clock);
    burst_clk <= 1'b0;
    address_valid_n <= 1'b1;
    out_en_n <= 1'b0;
    repeat (8) @(posedge clock);
    #1 v0 = {dq_oe, dq_o};
    @(posedge clock);
    burst_clk <= 1'b1;
    repeat (8) @(posedge clock);
    #1 v1 = {dq_oe, dq_o};
    @(posedge clock);
    chip_sel_n <= 1'b1;
    out_en_n <= 1'b1;
    burst_clk <= 1'b0;
    addr <= ~a;
    repeat (6) @(posedge clock);
  endtask

  // warm reset pin pulse
  task automatic pin_reset();
    @(posedge clock);
    warm_reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    warm_reset_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule

// >>> test_boot_command_and_ecc_result_port.sv
`timescale 1ns/1ps
module test_boot_command_and_ecc_result_port;
  import bcp_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] MK = 16'h1b2b; // arbitrary maker code
  localparam logic [15:0] DV = 16'h2d4d; // arbitrary device code
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_sel_n, out_en_n, write_n, warm_reset_n, address_valid_n, burst_clk;
  logic [15:0] addr, dq_i, dq_o, buf_addr, buf_wdata, load_block;
  logic dq_oe, buf_wr, load_req, core_reset;
  logic [5:0] load_page;
  logic [15:0] boot_rd_data = 16'h0000;
  logic [15:0] buf_rd_data = 16'h0000;
  logic [15:0] protect_status = 16'h0000;
  logic load_done = 1'b0;
  logic ecc_upd = 1'b0;
  logic ecc_upd_sector = 1'b0;
  logic [7:0] ecc_upd_word = 8'h00;
  logic [3:0] ecc_upd_main_lane = 4'h0;
  logic [1:0] ecc_upd_spare_sel = 2'h0;
  logic [3:0] ecc_upd_spare_lane = 4'h0;
  logic [35:0] q[$]; // expected events: kind, value
  logic [16:0] rd_val;
  logic [15:0] rnd = 16'h0059;
  logic [15:0] blk, m, sp;
  event rd_done;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 clock = ~clock;

  bcp_boot_cmd_port #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .PAGE_BITS(6)) i_dut (.clock(clock),
    .sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
    .warm_reset_n(warm_reset_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
    .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .boot_rd_data(boot_rd_data),
    .buf_rd_data(buf_rd_data), .protect_status(protect_status), .buf_wr(buf_wr),
    .buf_addr(buf_addr), .buf_wdata(buf_wdata), .load_req(load_req), .load_block(load_block),
    .load_page(load_page), .load_done(load_done), .core_reset(core_reset), .ecc_upd(ecc_upd),
    .ecc_upd_sector(ecc_upd_sector), .ecc_upd_word(ecc_upd_word),
    .ecc_upd_main_lane(ecc_upd_main_lane), .ecc_upd_spare_sel(ecc_upd_spare_sel),
    .ecc_upd_spare_lane(ecc_upd_spare_lane));

  bcp_host_model i_host (.clock(clock), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_n(write_n), .warm_reset_n(warm_reset_n), .address_valid_n(address_valid_n),
    .burst_clk(burst_clk), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic exp(input logic [3:0] k, input logic [31:0] v);
    q.push_back({k, v});
  endtask

  // compares one observed event against the oldest note
  task automatic got(input logic [3:0] k, input logic [31:0] v);
    logic [35:0] e;
    n_checks++;
    if (q.size() == 0) begin
      mismatches++;
      $display("[ERR] %0t unexpected event kind %0d value %h", $time, k, v);
    end else begin
      e = q.pop_front();
      if (e !== {k, v}) begin
        mismatches++;
        $display("[ERR] %0t saw %h wanted %h", $time, {k, v}, e);
      end
    end
  endtask

  // read expecting the bus driven with value v
  task automatic rdc(input logic [15:0] a, input logic [15:0] v);
    logic [16:0] r;
    exp(4'h4, {15'h0, 1'b1, v});
    i_host.rd(a, r);
    rd_val = r;
    ->rd_done;
  endtask

  // burst read of two words, both expected driven
  task automatic brdc(input logic [15:0] a, input logic [15:0] v0, input logic [15:0] v1);
    logic [16:0] r0, r1;
    exp(4'h4, {15'h0, 1'b1, v0});
    exp(4'h4, {15'h0, 1'b1, v1});
    i_host.brd(a, r0, r1);
    rd_val = r0;
    ->rd_done;
    @(posedge clock);
    rd_val = r1;
    ->rd_done;
  endtask

  // two-cycle load then the engine finishes it
  task automatic load(input logic [15:0] a);
    i_host.wr(a, CMD_LOAD_1);
    i_host.wr(a, CMD_LOAD_2);
    repeat (4) @(posedge clock);
    load_done <= 1'b1;
    @(posedge clock);
    load_done <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic give_verdict();
    if (q.size() != 0) begin
      mismatches++;
      $display("[ERR] %0t %0d expected events never seen", $time, q.size());
    end
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output monitor; register-space writes are not buffer traffic
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!sys_rst) begin
      if (core_reset) got(4'h3, 32'h0);
      if (load_req) got(4'h2, 32'({load_block, load_page}));
      if (buf_wr && buf_addr < 16'hf000) got(4'h1, {buf_addr, buf_wdata});
    end
  end
  always @(rd_done) got(4'h4, 32'(rd_val));

  // hang guard, far above the roughly 1150 cycles of the sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    rnd = nxt(rnd);
    boot_rd_data <= rnd;
    rdc(16'h0005, rnd);
    for (int i = 0; i < 4; i++) rdc(OFS_ECC2_MAIN + 16'(i), ECC_RESET);
    rnd = nxt(rnd);
    buf_rd_data <= rnd;
    rdc(16'h0400, rnd);
    exp(4'h1, {16'h0400, rnd});
    exp(4'h1, {16'h0401, ~rnd});
    i_host.bwr(16'h0400, rnd, ~rnd);
    // command codes just outside both boot ranges stay plain writes
    exp(4'h1, {16'h0200, CMD_RESET});
    i_host.wr(16'h0200, CMD_RESET);
    exp(4'h1, {16'h8010, CMD_LOAD_1});
    i_host.wr(16'h8010, CMD_LOAD_1);
    blk = nxt(rnd);
    i_host.wr(OFS_BLOCK_SEL, blk);
    i_host.wr(OFS_PAGE_SEL, 16'h0003 << PAGE_SEL_LSB);
    exp(4'h2, 32'({blk, 6'd3}));
    load(BOOT_HI_END);
    exp(4'h2, 32'({blk, 6'd4}));
    load(BOOT_LO_END);
    i_host.wr(OFS_PAGE_SEL, 16'h003f << PAGE_SEL_LSB);
    exp(4'h2, 32'({blk, 6'd63}));
    load(BOOT_HI_START);
    exp(4'h2, 32'({blk, 6'd0}));
    load(BOOT_LO_START);
    rdc(16'h0005, 16'h0000);
    // broken load sequence is dropped, a lone second cycle too
    i_host.wr(16'h0010, CMD_LOAD_1);
    i_host.wr(16'h0010, 16'h1234);
    i_host.wr(16'h0010, CMD_LOAD_2);
    exp(4'h2, 32'({blk, 6'd1}));
    load(16'h0010);
    // one result update per sector, both spare word codes
    for (int s = 0; s < 2; s++) begin
      rnd = nxt(rnd);
      @(posedge clock);
      ecc_upd <= 1'b1;
      ecc_upd_sector <= s[0];
      ecc_upd_word <= rnd[15:8];
      ecc_upd_main_lane <= rnd[3:0];
      ecc_upd_spare_sel <= s[1:0];
      ecc_upd_spare_lane <= rnd[7:4];
      @(posedge clock);
      ecc_upd <= 1'b0;
      m = (16'(rnd[15:8]) << WORD_POS_LSB) | 16'(rnd[3:0]);
      rdc(OFS_ECC2_MAIN + 16'(2 * s), m);
      sp = (16'(s[1:0]) << SPARE_SEL_LSB) | 16'(rnd[7:4]);
      rdc(OFS_ECC2_SPARE + 16'(2 * s), sp);
      brdc(OFS_ECC2_MAIN + 16'(2 * s), m, sp);
      i_host.wr(OFS_ECC2_MAIN + 16'(2 * s), 16'hffff);
      rdc(OFS_ECC2_MAIN + 16'(2 * s), m);
    end
    exp(4'h3, 32'h0);
    i_host.wr(BOOT_LO_START, CMD_RESET);
    for (int i = 0; i < 4; i++) rdc(OFS_ECC2_MAIN + 16'(i), 16'h0000);
    // identification, left by the next write strobe
    protect_status <= rnd;
    i_host.wr(16'h0100, CMD_READ_ID);
    rdc(ID_OFS_MAKER, MK);
    rdc(ID_OFS_DEVICE, DV);
    rdc(ID_OFS_PROTECT, rnd);
    exp(4'h1, {16'h0400, 16'h5a5a});
    i_host.wr(16'h0400, 16'h5a5a);
    rdc(ID_OFS_MAKER, 16'h0000);
    // warm reset pin brings the selects back to zero
    i_host.pin_reset();
    exp(4'h2, 32'({16'h0000, 6'd0}));
    load(16'h0000);
    repeat (10) @(posedge clock);
    give_verdict();
  end
endmodule
